// [itr_defs.vh]
// constants shared by the input telemetry register block
`ifndef ITR_DEFS_VH
`define ITR_DEFS_VH

// ****************************************
// register offsets on the serial bus
// ****************************************
`define ITR_ADDR_VIN 8'h12
`define ITR_ADDR_CUR 8'h13
`define ITR_ADDR_PWR 8'h14

// ****************************************
// widths and field layout
// ****************************************
`define ITR_ADDR_W 8
`define ITR_SENSE_W 12
`define ITR_PWM_W 8
`define ITR_VAL_W 16
`define ITR_CUR_LSB 4
`define ITR_CUR_PAD 4'h0
`define ITR_DIV_CNT_W 5
`define ITR_PWR_SHIFT 12

// ****************************************
// reset and default values
// ****************************************
`define ITR_VAL_RESET 16'h0000
`define ITR_VAL_SAT 16'hffff
`define ITR_BYTE_UNMAPPED 8'h00

`endif

// [itr_divider.v]
// iterative restoring divider, one quotient bit per clock
`include "itr_defs.vh"

module itr_divider #(
   parameter DVD_W = 20,
   parameter DVS_W = 8,
   parameter CNT_W = `ITR_DIV_CNT_W
)(
   input wire core_clk,
   input wire resetn,
   input wire start,
   input wire [DVD_W-1:0] dividend,
   input wire [DVS_W-1:0] divisor,
   output reg done_reg,
   output reg [DVD_W-1:0] quot_reg
);

   // step count cut to the counter width on purpose
   localparam integer LAST_INT = DVD_W - 1;
   localparam [CNT_W-1:0] LAST_STEP = LAST_INT[CNT_W-1:0];

   reg [DVS_W:0] rem_reg;
   reg [DVS_W-1:0] dvs_reg;
   reg [CNT_W-1:0] cnt_reg;
   reg busy_reg;
   wire [DVS_W:0] trial;
   wire take;

   // shift the next dividend bit into the partial remainder
   assign trial = {rem_reg[DVS_W-1:0], quot_reg[DVD_W-1]};
   assign take = (trial >= {1'b0, dvs_reg});

   // ****************************************
   // divide sequence
   // ****************************************
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rem_reg <= {(DVS_W+1){1'b0}};
         dvs_reg <= {DVS_W{1'b0}};
         cnt_reg <= {CNT_W{1'b0}};
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         quot_reg <= {DVD_W{1'b0}};
      end
      else
      begin
         done_reg <= 1'b0;
         if (start && !busy_reg)
         begin
            rem_reg <= {(DVS_W+1){1'b0}};
            dvs_reg <= divisor;
            quot_reg <= dividend;
            cnt_reg <= {CNT_W{1'b0}};
            busy_reg <= 1'b1;
         end
         else if (busy_reg)
         begin
            rem_reg <= take ? (trial - {1'b0, dvs_reg}) : trial;
            quot_reg <= {quot_reg[DVD_W-2:0], take};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == LAST_STEP)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end

endmodule // itr_divider

// [itr_telemetry.v]
// input voltage, current and power telemetry registers with byte reads
`include "itr_defs.vh"

module itr_telemetry #(
   parameter SENSE_W = `ITR_SENSE_W,
   parameter PWM_W = `ITR_PWM_W
)(
   input wire core_clk,
   input wire resetn,
   input wire sample_valid,
   input wire [SENSE_W-1:0] local_output_sense,
   input wire [SENSE_W-1:0] primary_current_sense,
   input wire [PWM_W-1:0] pwm_modulation,
   input wire xfer_start,
   input wire rd_strobe,
   input wire [`ITR_ADDR_W-1:0] rd_addr,
   output reg [7:0] rd_data_reg,
   output reg rd_valid_reg,
   output reg busy_reg,
   output reg [`ITR_VAL_W-1:0] input_voltage_value_reg,
   output reg [`ITR_VAL_W-1:0] input_current_value_reg,
   output reg [`ITR_VAL_W-1:0] input_power_value_reg
);

   localparam DVD_W = SENSE_W + PWM_W;
   localparam PROD_W = `ITR_VAL_W + SENSE_W;

   // one-hot sequencer states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_DIV = 3'b010;
   localparam [2:0] ST_MUL = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [SENSE_W-1:0] cur_cap_reg;
   reg zero_pwm_reg;
   reg [`ITR_VAL_W-1:0] vin_tmp_reg;
   reg second_reg;
   reg [`ITR_ADDR_W-1:0] held_addr_reg;
   reg [7:0] low_shadow_reg;
   reg [`ITR_VAL_W-1:0] rd_word;
   reg [`ITR_VAL_W-1:0] vin_sat;
   wire div_done;
   wire [DVD_W-1:0] quotient;
   wire [PROD_W-1:0] product;
   wire [`ITR_VAL_W:0] hit_word;
   wire start_div;
   wire addr_hit;
   wire is_second;

   // ****************************************
   // register word decode
   // ****************************************
   function [`ITR_VAL_W:0] word_of;
      input [`ITR_ADDR_W-1:0] a;
      input [`ITR_VAL_W-1:0] v;
      input [`ITR_VAL_W-1:0] c;
      input [`ITR_VAL_W-1:0] p;
      begin
         if (a == `ITR_ADDR_VIN)
            word_of = {1'b1, v};
         else if (a == `ITR_ADDR_CUR)
            word_of = {1'b1, c};
         else if (a == `ITR_ADDR_PWR)
            word_of = {1'b1, p};
         else
            word_of = {1'b0, `ITR_VAL_RESET};
      end
   endfunction

   // ****************************************
   // voltage derivation
   // ****************************************
   // a new sample is accepted only while the sequencer is idle
   assign start_div = sample_valid && (state_reg == ST_IDLE);

   // dividend is the sense code scaled by the full-scale pwm fraction
   itr_divider #(
      .DVD_W(DVD_W),
      .DVS_W(PWM_W),
      .CNT_W(`ITR_DIV_CNT_W)
   ) i_itr_divider (
      .core_clk(core_clk),
      .resetn(resetn),
      .start(start_div),
      .dividend({local_output_sense, {PWM_W{1'b0}}}),
      .divisor(pwm_modulation),
      .done_reg(div_done),
      .quot_reg(quotient)
   );

   // saturate quotient to 16 bits, zero modulation reads full scale
   always @*
   begin
      vin_sat = quotient[`ITR_VAL_W-1:0];
      if (zero_pwm_reg || (|quotient[DVD_W-1:`ITR_VAL_W]))
         vin_sat = `ITR_VAL_SAT;
   end

   // power product before scaling into 16 bits
   assign product = vin_tmp_reg * cur_cap_reg;

   // sequencer next state
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (start_div)
               state_next = ST_DIV;
         ST_DIV:
            if (div_done)
               state_next = ST_MUL;
         ST_MUL:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // ****************************************
   // sample pipeline and value registers
   // ****************************************
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= ST_IDLE;
         cur_cap_reg <= {SENSE_W{1'b0}};
         zero_pwm_reg <= 1'b0;
         vin_tmp_reg <= `ITR_VAL_RESET;
         busy_reg <= 1'b0;
         input_voltage_value_reg <= `ITR_VAL_RESET;
         input_current_value_reg <= `ITR_VAL_RESET;
         input_power_value_reg <= `ITR_VAL_RESET;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg <= (state_next != ST_IDLE);
         if (start_div)
         begin
            // raw code, zero volts gives zero counts
            cur_cap_reg <= primary_current_sense;
            zero_pwm_reg <= (pwm_modulation == {PWM_W{1'b0}});
         end
         if (state_reg == ST_DIV && div_done)
            vin_tmp_reg <= vin_sat;
         if (state_reg == ST_MUL)
         begin
            // all three words change together on one edge
            input_voltage_value_reg <= vin_tmp_reg;
            input_current_value_reg <= {cur_cap_reg, `ITR_CUR_PAD};
            input_power_value_reg <=
               product[`ITR_PWR_SHIFT+`ITR_VAL_W-1:`ITR_PWR_SHIFT];
         end
      end
   end

   // ****************************************
   // byte read port
   // ****************************************
   // a read is the second half when it repeats the held address while a first half is pending
   assign is_second = second_reg && (rd_addr == held_addr_reg);

   // decode once: top bit flags a mapped address, the rest is the word
   assign hit_word = word_of(rd_addr, input_voltage_value_reg,
      input_current_value_reg, input_power_value_reg);
   assign addr_hit = hit_word[`ITR_VAL_W];

   // word of the addressed register, zero when unmapped
   always @*
   begin
      rd_word = hit_word[`ITR_VAL_W-1:0];
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_data_reg <= `ITR_BYTE_UNMAPPED;
         rd_valid_reg <= 1'b0;
         second_reg <= 1'b0;
         held_addr_reg <= {`ITR_ADDR_W{1'b0}};
         low_shadow_reg <= `ITR_BYTE_UNMAPPED;
      end
      else
      begin
         rd_valid_reg <= rd_strobe;
         if (rd_strobe)
         begin
            if (!addr_hit)
            begin
               rd_data_reg <= `ITR_BYTE_UNMAPPED;
               second_reg <= 1'b0;
            end
            else if (is_second)
            begin
               // lower byte from the snapshot taken at the first read
               rd_data_reg <= low_shadow_reg;
               second_reg <= 1'b0;
            end
            else
            begin
               rd_data_reg <= rd_word[15:8];
               low_shadow_reg <= rd_word[7:0];
               held_addr_reg <= rd_addr;
               second_reg <= 1'b1;
            end
         end
         else if (xfer_start)
            second_reg <= 1'b0;
      end
   end

endmodule // itr_telemetry

// [itr_props.sv]
// checker for the input telemetry register ports
module itr_props (
   input wire core_clk,
   input wire resetn,
   input wire sample_valid,
   input wire [11:0] primary_current_sense,
   input wire [7:0] pwm_modulation,
   input wire rd_strobe,
   input wire [7:0] rd_addr,
   input wire [7:0] rd_data_reg,
   input wire busy_reg,
   input wire rd_valid_reg,
   input wire [15:0] input_voltage_value_reg,
   input wire [15:0] input_current_value_reg,
   input wire [15:0] input_power_value_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [31:0] pwr_full;
   // full product before the 12-bit scale
   assign pwr_full = input_voltage_value_reg * input_current_value_reg[15:4];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_rd_answer: assert property (rd_strobe |=> rd_valid_reg)
      else $error("read gave no answer");
   a_unmapped_zero: assert property (rd_strobe &&
      !(rd_addr inside {8'h12, 8'h13, 8'h14}) |=> rd_data_reg == 8'h00)
      else $error("unmapped read not zero");
   a_cur_pad: assert property (input_current_value_reg[3:0] == 4'h0)
      else $error("current low bits set");
   a_take_latency: assert property (sample_valid && !busy_reg |=>
      busy_reg [*8] ##14 busy_reg ##1 !busy_reg)
      else $error("sample latency wrong");
   a_cur_code: assert property ($fell(busy_reg) |->
      input_current_value_reg[15:4] == $past(primary_current_sense, 23))
      else $error("current code wrong");
   a_pwr_product: assert property ($fell(busy_reg) |->
      input_power_value_reg == pwr_full[27:12])
      else $error("power not the product");
   a_vin_sat: assert property ($fell(busy_reg) &&
      $past(pwm_modulation, 23) == 8'h00 |->
      input_voltage_value_reg == 16'hffff)
      else $error("zero modulation not saturated");
   a_values_hold: assert property (!busy_reg |=>
      $stable(input_power_value_reg) && $stable(input_voltage_value_reg))
      else $error("values moved while idle");
endmodule // itr_props

// [itr_host.sv]
// host model issuing byte reads on the register read port
module itr_host (
   input wire core_clk,
   input wire rd_valid_reg,
   input wire [7:0] rd_data_reg,
   output logic rd_strobe,
   output logic [7:0] rd_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rd_strobe = 1'b0;
   initial rd_addr = 8'h00;
   // one byte read: pulse, then take the answer once settled
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      rd_strobe <= 1'b1;
      rd_addr <= a;
      @(posedge core_clk);
      rd_strobe <= 1'b0;
      rd_addr <= ~a; // stale address never left on the lines
      @(negedge core_clk);
      d = rd_valid_reg ? rd_data_reg : 8'hxx;
   endtask
endmodule // itr_host

// [test_input_telemetry_registers.sv]
// self-checking bench for the input telemetry registers
module test_input_telemetry_registers;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, resetn = 1'b0, sample_valid = 1'b0;
   logic xfer_start = 1'b0, rd_strobe, rd_valid_reg, busy_reg;
   logic [11:0] vs = 12'h000, cur = 12'h000;
   logic [7:0] pwm = 8'h00, rd_addr, rd_data_reg, b;
   logic [15:0] vin, ic, pw, ev, ep, old;
   logic [31:0] q;
   logic [31:0] tv [3] = '{32'ha53b98c0, 32'hfff00000, 32'h001fffff};
   int error_cnt = 0, n_compared = 0, cycles = 0;
   itr_telemetry i_itr_telemetry (.core_clk(core_clk), .resetn(resetn),
      .sample_valid(sample_valid), .local_output_sense(vs),
      .primary_current_sense(cur), .pwm_modulation(pwm),
      .xfer_start(xfer_start), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
      .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
      .busy_reg(busy_reg), .input_voltage_value_reg(vin),
      .input_current_value_reg(ic), .input_power_value_reg(pw));
   itr_host i_itr_host (.core_clk(core_clk), .rd_valid_reg(rd_valid_reg),
      .rd_data_reg(rd_data_reg), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
   // clock and hang guard
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one sample, with a refused second request while busy
   task sample(input logic [31:0] t);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      {vs, cur, pwm} <= t;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      repeat (5) @(posedge core_clk);
      sample_valid <= 1'b1;
      {vs, cur} <= ~t[31:8];
      @(posedge core_clk);
      sample_valid <= 1'b0;
      {vs, cur} <= t[31:8];
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      q = (t[7:0] == 8'h00) ? 32'hffff : {t[31:20], 8'h00} / t[7:0];
      ev = (q > 32'hffff) ? 16'hffff : q[15:0];
      q = ev * t[19:8];
      ep = q[27:12];
      check(busy_reg, 16'h0000);
      check(vin, ev);
      check(ic, {t[19:8], 4'h0});
      check(pw, ep);
   endtask
   task rd_pair(input logic [7:0] a, input logic [15:0] e);
      i_itr_host.read(a, b);
      check(b, e[15:8]);
      i_itr_host.read(a, b);
      check(b, e[7:0]);
   endtask
   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         sample(tv[i]);
         rd_pair(8'h12, ev);
         rd_pair(8'h13, {tv[i][19:8], 4'h0});
         rd_pair(8'h14, ep);
      end
      old = ep;
      i_itr_host.read(8'h14, b);
      sample(tv[0]);
      i_itr_host.read(8'h14, b);
      check(b, old[7:0]);
      i_itr_host.read(8'h20, b);
      check(b, 16'h0000);
      i_itr_host.read(8'h12, b);
      @(posedge core_clk);
      xfer_start <= 1'b1;
      @(posedge core_clk);
      xfer_start <= 1'b0;
      rd_pair(8'h12, ev);
      // reset in mid-sample clears every word and the busy flag
      @(posedge core_clk);
      sample_valid <= 1'b1;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk);
      check(busy_reg, 16'h0000);
      check(vin, 16'h0000);
      check(ic, 16'h0000);
      check(pw, 16'h0000);
      final_report();
   end
endmodule // test_input_telemetry_registers
bind itr_telemetry itr_props i_itr_props (.core_clk(core_clk),
   .resetn(resetn), .sample_valid(sample_valid),
   .primary_current_sense(primary_current_sense),
   .pwm_modulation(pwm_modulation), .rd_strobe(rd_strobe),
   .rd_addr(rd_addr), .rd_data_reg(rd_data_reg), .busy_reg(busy_reg),
   .rd_valid_reg(rd_valid_reg),
   .input_voltage_value_reg(input_voltage_value_reg),
   .input_current_value_reg(input_current_value_reg),
   .input_power_value_reg(input_power_value_reg));
